/* File: core/svwm_pkg.sv */
package svwm_pkg;
   // register byte addresses on the apb slave
   localparam logic [11:0] ADDR_CTRL_STAT = 12'h000;
   localparam logic [11:0] ADDR_TRIP_SEL = 12'h004;
   localparam logic [11:0] ADDR_EVENT = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h00c;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;

   // detector_control_status field positions
   localparam int CTRL_EN_BIT = 7;
   localparam int CTRL_RESULT_BIT = 5;
   localparam int CTRL_READY_BIT = 4;
   localparam int CTRL_RISE_BIT = 1;
   localparam int CTRL_FALL_BIT = 0;

   // trip_level_select field
   localparam int TRIP_MSB = 3;
   localparam int TRIP_W = 4;

   // event and interrupt status bit positions
   localparam int EVT_FLAG_BIT = 0;
   localparam int IRQ_EVT_BIT = 0;
   localparam int IRQ_W = 1;

   // reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [3:0] TRIP_RST = 4'h0;
   localparam logic [0:0] IRQ_MASK_RST = 1'h0;

   // reference start-up interval, in ns, and its cycle count at 100 mhz
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int REF_SETTLE_NS = 25000;
   localparam int REF_SETTLE_CYC =
      (REF_SETTLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
   localparam int SETTLE_CNT_W = 12;

   // software-written detector controls travel together
   typedef struct packed {
      logic en;
      logic rise;
      logic fall;
   } svwm_ctrl_t;

   // detector power-up sequencing
   typedef enum logic [2:0] {
      ST_OFF = 3'b001,
      ST_SETTLE = 3'b010,
      ST_READY = 3'b100
   } svwm_state_t;
endpackage

/* File: core/svwm_top.sv */
`timescale 1ns/1ps

// Functional notes
// R1 - enable powers detector, off means no activity
// R2 - result bit reads 1 at/below trip
// R3 - ready bit set once reference is stable
// R4 - rise enable lets upward crossing set flag
// R5 - fall enable lets downward crossing set flag
// R6 - four-bit read/write trip level field
// R7 - unused bits read zero, ignore writes
// R8 - no event before reference settle time elapses
// R9 - keeps monitoring in sleep, event wakes device
// R10 - fully active in idle and doze
// R11 - freeze blocks new events, holds ready
// R12 - registers stay accessible during freeze
// R13 - reset clears enables and trip level
// R14 - toggling enable never makes spurious event
// R15 - software disables before changing settings
// R16 - event flag sticky until software clears
module svwm_top #(
   parameter int SETTLE_CYC = svwm_pkg::REF_SETTLE_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog detector
   input wire logic cmp_below,
   output logic det_power_en,
   output logic [3:0] det_trip_level,
   // system
   input wire logic debug_freeze,
   output logic wake_req,
   output logic irq
);

   // the settle counter must be able to reach SETTLE_CYC - 1
   if (SETTLE_CYC < 1 ||
       SETTLE_CYC >= (1 << svwm_pkg::SETTLE_CNT_W)) begin
      $error("svwm_top: SETTLE_CYC out of range");
   end
   // the trip field and the irq event bit must fit their registers
   if (svwm_pkg::TRIP_MSB + 1 != svwm_pkg::TRIP_W) begin
      $error("svwm_top: trip field width mismatch");
   end
   if (svwm_pkg::IRQ_EVT_BIT >= svwm_pkg::IRQ_W) begin
      $error("svwm_top: irq event bit outside irq vector");
   end

   svwm_pkg::svwm_ctrl_t ctrl_r;
   logic [3:0] trip_r;
   logic result_r;
   logic ready_r;
   logic evt_flag_r;
   logic [svwm_pkg::IRQ_W-1:0] irq_stat_r;
   logic [svwm_pkg::IRQ_W-1:0] irq_mask_r;
   svwm_pkg::svwm_state_t state_r;
   svwm_pkg::svwm_state_t state_nxt;
   logic [svwm_pkg::SETTLE_CNT_W-1:0] settle_cnt_r;
   logic base_valid_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic wake_r;
   logic irq_r;

   logic setup_ph;
   logic acc_done;
   logic wr_acc;
   logic rd_acc;
   logic addr_ok;
   logic cross_up;
   logic cross_down;
   logic evt_set;
   logic settle_done;
   logic evt_clr;
   logic [svwm_pkg::IRQ_W-1:0] irq_set;
   logic irq_clr;

   // apb: data and pready are registered in the setup cycle, so every
   // access completes with exactly one access cycle and no wait state
   assign setup_ph = psel && !penable;
   assign acc_done = psel && penable && pready_r;
   assign wr_acc = acc_done && pwrite && !pslverr_r;
   assign rd_acc = acc_done && !pwrite && !pslverr_r;

   always_comb begin
      case (paddr)
         svwm_pkg::ADDR_CTRL_STAT: addr_ok = 1'b1;
         svwm_pkg::ADDR_TRIP_SEL: addr_ok = 1'b1;
         svwm_pkg::ADDR_EVENT: addr_ok = 1'b1;
         svwm_pkg::ADDR_IRQ_STAT: addr_ok = 1'b1;
         svwm_pkg::ADDR_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // no register or sleep/idle/doze input gates this path, so bus access
   // continues in every power mode and in freeze, and monitoring in every power mode
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= setup_ph; // [R12]
         pslverr_r <= setup_ph && !addr_ok;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_ph) begin
         prdata_r <= 32'h0000_0000; // [R7]
         if (!pwrite) begin
            case (paddr)
               svwm_pkg::ADDR_CTRL_STAT: begin
                  prdata_r[svwm_pkg::CTRL_EN_BIT] <= ctrl_r.en;
                  prdata_r[svwm_pkg::CTRL_RESULT_BIT] <= result_r; // [R2]
                  prdata_r[svwm_pkg::CTRL_READY_BIT] <= ready_r; // [R3]
                  prdata_r[svwm_pkg::CTRL_RISE_BIT] <= ctrl_r.rise;
                  prdata_r[svwm_pkg::CTRL_FALL_BIT] <= ctrl_r.fall;
               end
               svwm_pkg::ADDR_TRIP_SEL: begin
                  prdata_r[svwm_pkg::TRIP_MSB:0] <= trip_r; // [R6]
               end
               svwm_pkg::ADDR_EVENT: begin
                  prdata_r[svwm_pkg::EVT_FLAG_BIT] <= evt_flag_r;
               end
               svwm_pkg::ADDR_IRQ_STAT: begin
                  prdata_r[svwm_pkg::IRQ_W-1:0] <= irq_stat_r;
               end
               svwm_pkg::ADDR_IRQ_MASK: begin
                  prdata_r[svwm_pkg::IRQ_W-1:0] <= irq_mask_r;
               end
               default: begin
                  prdata_r <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // control registers: only the documented bits are stored
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_r.en <= svwm_pkg::CTRL_RST[svwm_pkg::CTRL_EN_BIT]; // [R13]
         ctrl_r.rise <= svwm_pkg::CTRL_RST[svwm_pkg::CTRL_RISE_BIT];
         ctrl_r.fall <= svwm_pkg::CTRL_RST[svwm_pkg::CTRL_FALL_BIT];
      end else if (wr_acc && paddr == svwm_pkg::ADDR_CTRL_STAT) begin
         ctrl_r.en <= pwdata[svwm_pkg::CTRL_EN_BIT]; // [R1]
         ctrl_r.rise <= pwdata[svwm_pkg::CTRL_RISE_BIT]; // [R4]
         ctrl_r.fall <= pwdata[svwm_pkg::CTRL_FALL_BIT]; // [R5]
      end
   end

   // settings are taken live; software is expected to disable first,
   // the baseline restart on enable hides the effect of doing so
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trip_r <= svwm_pkg::TRIP_RST; // [R13]
      end else if (wr_acc && paddr == svwm_pkg::ADDR_TRIP_SEL) begin
         trip_r <= pwdata[svwm_pkg::TRIP_MSB:0]; // [R6] [R15]
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_mask_r <= svwm_pkg::IRQ_MASK_RST;
      end else if (wr_acc && paddr == svwm_pkg::ADDR_IRQ_MASK) begin
         irq_mask_r <= pwdata[svwm_pkg::IRQ_W-1:0];
      end
   end

   // power-up sequencing of the reference
   assign settle_done =
      settle_cnt_r == svwm_pkg::SETTLE_CNT_W'(SETTLE_CYC - 1);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         svwm_pkg::ST_OFF: begin
            if (ctrl_r.en) begin
               state_nxt = svwm_pkg::ST_SETTLE;
            end
         end
         svwm_pkg::ST_SETTLE: begin
            if (!ctrl_r.en) begin
               state_nxt = svwm_pkg::ST_OFF;
            end else if (settle_done && !debug_freeze) begin
               state_nxt = svwm_pkg::ST_READY; // [R8]
            end
         end
         svwm_pkg::ST_READY: begin
            if (!ctrl_r.en) begin
               state_nxt = svwm_pkg::ST_OFF;
            end
         end
         default: begin
            state_nxt = svwm_pkg::ST_OFF;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= svwm_pkg::ST_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   // the interval counts sys_clk only; freeze pauses it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         settle_cnt_r <= '0;
      end else if (state_r != svwm_pkg::ST_SETTLE) begin
         settle_cnt_r <= '0;
      end else if (!debug_freeze && !settle_done) begin
         settle_cnt_r <= settle_cnt_r + 1'b1; // [R8]
      end
   end

   // ready bit is frozen under debug freeze, even across a disable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         ready_r <= 1'b0;
      end else if (!debug_freeze) begin
         ready_r <= state_nxt == svwm_pkg::ST_READY; // [R3] [R11]
      end
   end

   // comparator result is only sampled while state_r is ST_READY, which lasts one cycle past a disable
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         result_r <= 1'b0;
      end else if (state_r == svwm_pkg::ST_READY) begin
         result_r <= cmp_below; // [R2] [R1]
      end
   end

   // the first valid sample is a baseline, not an event: a level
   // present at enable time never shows up as a crossing
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         base_valid_r <= 1'b0;
      end else begin
         base_valid_r <= state_r == svwm_pkg::ST_READY && ctrl_r.en; // [R14]
      end
   end

   assign cross_up = base_valid_r && result_r && !cmp_below;
   assign cross_down = base_valid_r && !result_r && cmp_below;
   assign evt_set = state_r == svwm_pkg::ST_READY && ctrl_r.en &&
      !debug_freeze && // [R11]
      ((ctrl_r.rise && cross_up) || // [R4]
       (ctrl_r.fall && cross_down)); // [R5] [R10]

   // event flag: write 1 to clear, a new event wins over the clear
   assign evt_clr = wr_acc && paddr == svwm_pkg::ADDR_EVENT &&
      pwdata[svwm_pkg::EVT_FLAG_BIT];

   svwm_sticky #(.W(1)) u_evt_flag (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .set(evt_set), // [R16]
      .clr(evt_clr), // [R16]
      .flags_r(evt_flag_r)
   );

   // interrupt status: read clears, set wins over the read
   always_comb begin
      irq_set = '0;
      irq_set[svwm_pkg::IRQ_EVT_BIT] = evt_set;
   end

   assign irq_clr = rd_acc && paddr == svwm_pkg::ADDR_IRQ_STAT;

   svwm_sticky #(.W(svwm_pkg::IRQ_W)) u_irq_stat (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .set(irq_set),
      .clr(irq_clr),
      .flags_r(irq_stat_r)
   );

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_r & irq_mask_r);
      end
   end

   // wake from sleep regardless of the mask; whether the cpu vectors
   // is decided by irq_mask_r on irq here and by its global interrupt enable outside
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         wake_r <= 1'b0;
      end else begin
         wake_r <= evt_set; // [R9]
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign det_power_en = ctrl_r.en; // [R1]
   assign det_trip_level = trip_r;
   assign wake_req = wake_r;
   assign irq = irq_r;

endmodule

// status bits that hardware sets and software clears; a set in the
// same cycle as a clear wins, so no event is lost to an early clear
module svwm_sticky #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // set and clear requests
   input wire logic [W-1:0] set,
   input wire logic clr,
   // sticky state
   output logic [W-1:0] flags_r
);

   if (W < 1) begin
      $error("svwm_sticky: W must be at least 1");
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         flags_r <= '0;
      end else begin
         flags_r <= set | (flags_r & ~{W{clr}});
      end
   end

endmodule

/* File: tb/svwm_assertions.sv */
`timescale 1ns/1ps
module svwm_assertions #(
   parameter int SETTLE_CYC = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // detector and system
   input wire logic cmp_below,
   input wire logic det_power_en,
   input wire logic [3:0] det_trip_level,
   input wire logic debug_freeze,
   input wire logic wake_req,
   input wire logic irq
);
   logic acc;
   assign acc = psel && penable && pready;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   chk_pready_after_setup: assert property (
      psel && !penable |=> pready) else $error("no access answer");
   chk_enable_follows: assert property (
      acc && pwrite && paddr == svwm_pkg::ADDR_CTRL_STAT
      |=> det_power_en == $past(pwdata[7])) else $error("enable pin");
   chk_trip_follows: assert property (
      acc && pwrite && paddr == svwm_pkg::ADDR_TRIP_SEL
      |=> det_trip_level == $past(pwdata[3:0])) else $error("trip pin");
   chk_trip_upper_zero: assert property (
      acc && !pwrite && paddr == svwm_pkg::ADDR_TRIP_SEL
      |-> prdata[31:4] == 28'h0) else $error("trip upper bits");
   chk_no_early_wake: assert property (
      $rose(det_power_en) |-> !wake_req [*6]) else $error("early event");
   chk_freeze_no_wake: assert property (
      debug_freeze [*3] |-> !wake_req) else $error("event in freeze");
   chk_off_no_wake: assert property (
      !det_power_en [*3] |-> !wake_req) else $error("event while off");
   chk_reset_off: assert property (disable iff (1'b0)
      !nrst |-> !det_power_en && det_trip_level == 4'h0 && !irq)
      else $error("outputs live in reset");
   cover property ($rose(wake_req));
   cover property (acc && pslverr);
   cover property (debug_freeze && acc && pwrite);
endmodule

/* File: tb/svwm_top_test.sv */
`timescale 1ns/1ps
module svwm_top_test;
   localparam logic [11:0] A_CT = svwm_pkg::ADDR_CTRL_STAT;
   localparam logic [11:0] A_TR = svwm_pkg::ADDR_TRIP_SEL;
   localparam logic [11:0] A_EV = svwm_pkg::ADDR_EVENT;
   localparam logic [11:0] A_IS = svwm_pkg::ADDR_IRQ_STAT;
   localparam logic [11:0] A_IM = svwm_pkg::ADDR_IRQ_MASK;
   // nrst starts unknown so that its fall to 0 is an edge the reset sees
   logic sys_clk = 0, nrst, psel = 0, penable = 0, pwrite = 0;
   logic cmp_below = 0, debug_freeze = 0, pready, pslverr, e;
   logic det_power_en, wake_req, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, q;
   logic [3:0] det_trip_level;
   int n_errors = 0, total_checks = 0, n_wake = 0;
   svwm_top #(.SETTLE_CYC(4)) dut (.sys_clk(sys_clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .cmp_below(cmp_below),
      .det_power_en(det_power_en), .det_trip_level(det_trip_level),
      .debug_freeze(debug_freeze), .wake_req(wake_req), .irq(irq));
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (wake_req === 1'b1) n_wake++;
   end
   task end_of_test;
      if (n_errors == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      total_checks++;
      if (g !== ex) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, ex, g);
      end
   endtask
   // holds the whole request until pready is seen high at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 1, 0);
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
   endtask
   task rd(input logic [11:0] a);
      apb(0, a, 0);
   endtask
   task wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   initial begin
      nrst <= 1'b0;
      wt(16);
      nrst <= 1;
      rd(A_CT); chk("ctrl", 0, q);
      rd(A_TR); chk("trip", 0, q);
      wr(A_TR, 32'hffffffff); rd(A_TR); chk("trip", 32'hf, q);
      chk("trip_pin", 32'hf, {28'h0, det_trip_level});
      wr(A_CT, 32'hffffff7f); rd(A_CT);
      chk("ctrl", 3, q & 32'hffffffcf);
      wr(A_IM, 1);
      wr(A_CT, 32'h81); wt(1); chk("power", 1, {31'h0, det_power_en});
      rd(A_CT); chk("ctrl", 32'h81, q & 32'hffffffdf);
      wt(10); rd(A_CT); chk("ctrl", 32'h91, q);
      rd(A_EV); chk("event", 0, q);
      cmp_below <= 1; wt(4);
      chk("irq", 1, {31'h0, irq});
      rd(A_CT); chk("ctrl", 32'hb1, q);
      rd(A_EV); chk("event", 1, q);
      chk("wakes", 1, n_wake);
      cmp_below <= 0; wt(4);
      rd(A_EV); chk("event", 1, q);
      rd(A_IS); chk("irq_stat", 1, q);
      rd(A_IS); chk("irq_stat", 0, q);
      wt(2); chk("irq", 0, {31'h0, irq});
      wr(A_EV, 1); rd(A_EV); chk("event", 0, q);
      // settings change only while off, as software must
      wr(A_CT, 0); wr(A_IM, 0); wr(A_CT, 32'h82); wt(10);
      cmp_below <= 1; wt(4); rd(A_EV); chk("event", 0, q);
      cmp_below <= 0; wt(4); rd(A_EV); chk("event", 1, q);
      chk("irq", 0, {31'h0, irq});
      wr(A_IM, 1); wt(2); chk("irq", 1, {31'h0, irq});
      rd(A_IS); chk("irq_stat", 1, q);
      chk("wakes", 2, n_wake);
      wr(A_EV, 1); debug_freeze <= 1; cmp_below <= 1; wt(4);
      cmp_below <= 0; wt(4);
      wr(A_TR, 9); rd(A_TR); chk("trip", 9, q);
      rd(A_CT); chk("ready", 32'h10, q & 32'h10);
      rd(A_EV); chk("event", 0, q);
      debug_freeze <= 0; wr(A_CT, 0); wt(3);
      chk("power", 0, {31'h0, det_power_en});
      rd(A_CT); chk("ctrl", 0, q & 32'hffffffdf);
      cmp_below <= 1; wt(4); rd(A_EV); chk("event", 0, q);
      rd(12'h014); chk("err", 1, {31'h0, e}); chk("rdata", 0, q);
      wr(A_CT, 32'h83); wr(A_TR, 7); nrst <= 0; wt(2);
      chk("power", 0, {31'h0, det_power_en});
      chk("trip_pin", 0, {28'h0, det_trip_level});
      nrst <= 1; rd(A_CT); chk("ctrl", 0, q);
      end_of_test;
   end
   initial begin
      wt(20000);
      n_errors++;
      end_of_test;
   end
endmodule
bind svwm_top svwm_assertions #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
   .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .cmp_below(cmp_below),
   .det_power_en(det_power_en), .det_trip_level(det_trip_level),
   .debug_freeze(debug_freeze), .wake_req(wake_req), .irq(irq));
